// >>> edc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "edc_map.svh"

// How it works
// - Wait 200 us after reset, then eight column-first refreshes before access.
// - Redo the eight-refresh wake-up whenever a full refresh period is missed.
// - Refresh one row every 781 cycles so 1,024 rows fit in 16 ms.
// - Strobes return high for precharge before each new cycle clears output.
// - Write strobe stays high throughout every read column cycle.
// - Page-mode column cycles spaced at least 25 ns apart.
// - Row strobe low at least 60 ns and below 100,000 ns.
// - Page read-write column cycle lasts at least 68 ns.
// - Late write strobe waits 77 ns after row, 32 after column, 47 after address.
// - Early write asserts write strobe before the column strobe falls.
// - Column strobe low 5 ns before row strobe, held 10 ns after.
// - Output gate low no later than row strobe falling in refresh.
// - Write strobe pulses last at least 10 ns; device releases data.
// - Lane strobes enabled by the byte enables fall together, both rise together, low well over 10 ns.
// - Write data and write strobe timing measured from write strobe fall.
module edc_ctrl #(
  parameter int unsigned PWRUP_CYC = `EDC_PWR_CYC,
  parameter int unsigned RASP_CYC  = `EDC_RASP_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_rmw,
  input  wire logic [19:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_be,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic             init_done,
  output logic [9:0]       dram_addr,
  output logic             row_strobe_n,
  output logic             lower_lane_column_strobe_n,
  output logic             upper_lane_column_strobe_n,
  output logic             write_strobe_n,
  output logic             output_gate_n,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);

  localparam logic [15:0] PWR_LAST = 16'(PWRUP_CYC - 1);
  localparam logic [12:0] RAS_LIM  = 13'(RASP_CYC - `EDC_COL_GUARD);
  localparam logic [9:0]  REF_LAST = 10'(`EDC_REF_CYC - 1);
  localparam logic [10:0] DEBT_MAX = 11'(`EDC_ROWS);
  localparam logic [2:0]  TRAS_END = 3'(`EDC_TRAS_CYC - 1);
  localparam logic [2:0]  TRP_END  = 3'(`EDC_TRP_CYC - 1);

  edc_pkg::edc_state_t st_q;

  logic [15:0] pwr_cnt_q;
  logic [9:0]  ref_cnt_q;
  logic [10:0] debt_q;
  logic [3:0]  wake_q;
  logic [12:0] ras_cnt_q;
  logic [2:0]  cnt_q;
  logic [9:0]  row_q;
  logic [9:0]  col_q;
  logic [1:0]  be_q;
  logic        wr_q;
  logic        rmw_q;
  logic [15:0] wdata_q;

  logic        pwr_end;
  logic        ref_tick;
  logic        ref_done;
  logic        no_ref;
  logic        row_hit;
  logic        ras_long;
  logic [2:0]  col_last;

  assign pwr_end  = (pwr_cnt_q == PWR_LAST);
  assign ref_tick = (ref_cnt_q == REF_LAST) && (st_q != edc_pkg::st_pwr);
  assign ref_done = (st_q == edc_pkg::st_rcas);
  assign no_ref   = (debt_q == 11'h000) && (wake_q == 4'h0);
  assign row_hit  = (req_addr[`EDC_ROW_MSB:`EDC_ROW_LSB] == row_q);
  assign ras_long = (ras_cnt_q >= RAS_LIM);
  assign col_last = rmw_q ? `EDC_RMW_LAST : `EDC_RD_LAST;
  assign init_done = (st_q != edc_pkg::st_pwr) && (wake_q == 4'h0);

  // Requests taken only when no refresh is owed
  always_comb begin
    case (st_q)
      edc_pkg::st_idle: req_ready = no_ref;
      edc_pkg::st_open: req_ready = no_ref && row_hit && !ras_long;
      default:          req_ready = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt_q <= 16'h0000;
    end else if (st_q == edc_pkg::st_pwr && !pwr_end) begin
      pwr_cnt_q <= pwr_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_q <= 10'h000;
    end else if (ref_tick || ref_cnt_q == REF_LAST) begin
      ref_cnt_q <= 10'h000;
    end else begin
      ref_cnt_q <= ref_cnt_q + 10'h001;
    end
  end

  // Refresh debt and wake-up count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      debt_q <= 11'h000;
      wake_q <= 4'h0;
    end else if (st_q == edc_pkg::st_pwr && pwr_end) begin
      wake_q <= `EDC_WAKE_CNT;
    end else if (debt_q == DEBT_MAX) begin
      wake_q <= `EDC_WAKE_CNT;
      debt_q <= 11'h000;
    end else if (ref_done && wake_q != 4'h0) begin
      wake_q <= wake_q - 4'h1;
      debt_q <= debt_q + {10'h000, ref_tick};
    end else begin
      case ({ref_tick, ref_done})
        2'b10:   debt_q <= debt_q + 11'h001;
        2'b01:   debt_q <= debt_q - 11'h001;
        default: debt_q <= debt_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ras_cnt_q <= 13'h0000;
    end else if (st_q == edc_pkg::st_ras) begin
      ras_cnt_q <= 13'h0000;
    end else if (!ras_long) begin
      ras_cnt_q <= ras_cnt_q + 13'h0001;
    end
  end

  // Request latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_q   <= 10'h000;
      col_q   <= 10'h000;
      be_q    <= 2'h0;
      wr_q    <= 1'b0;
      rmw_q   <= 1'b0;
      wdata_q <= 16'h0000;
    end else if (req_valid && req_ready) begin
      row_q   <= req_addr[`EDC_ROW_MSB:`EDC_ROW_LSB];
      col_q   <= req_addr[`EDC_COL_MSB:0];
      be_q    <= req_be;
      wr_q    <= req_write && !req_rmw;
      rmw_q   <= req_rmw;
      wdata_q <= req_wdata;
    end
  end

  // Strobe sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q                       <= edc_pkg::st_pwr;
      cnt_q                      <= 3'h0;
      dram_addr                  <= 10'h000;
      row_strobe_n               <= 1'b1;
      lower_lane_column_strobe_n <= 1'b1;
      upper_lane_column_strobe_n <= 1'b1;
      write_strobe_n             <= 1'b1;
      output_gate_n              <= 1'b1;
      dq_o                       <= 16'h0000;
      dq_oe                      <= 1'b0;
      rd_valid                   <= 1'b0;
      rd_data                    <= 16'h0000;
    end else begin
      rd_valid <= 1'b0;
      case (st_q)
        edc_pkg::st_pwr: begin
          if (pwr_end) begin
            st_q <= edc_pkg::st_idle;
          end
        end
        edc_pkg::st_idle: begin
          if (!no_ref) begin
            // column strobes lead the row strobe
            lower_lane_column_strobe_n <= 1'b0;
            upper_lane_column_strobe_n <= 1'b0;
            // output gate low before row strobe
            output_gate_n              <= 1'b0;
            st_q                       <= edc_pkg::st_rcas;
          end else if (req_valid) begin
            // row half on the address pins
            dram_addr <= req_addr[`EDC_ROW_MSB:`EDC_ROW_LSB];
            st_q      <= edc_pkg::st_ras;
          end
        end
        edc_pkg::st_ras: begin
          row_strobe_n <= 1'b0;
          st_q         <= edc_pkg::st_col;
        end
        edc_pkg::st_col: begin
          // column half on the address pins
          dram_addr <= col_q;
          if (wr_q) begin
            // early write before the column strobe
            // outputs stay open for the cycle
            // data ready at the write strobe fall
            write_strobe_n <= 1'b0;
            dq_o           <= wdata_q;
            dq_oe          <= 1'b1;
          end else begin
            output_gate_n <= 1'b0;
          end
          st_q <= edc_pkg::st_cas;
        end
        edc_pkg::st_cas: begin
          lower_lane_column_strobe_n <= !be_q[0];
          upper_lane_column_strobe_n <= !be_q[1];
          cnt_q                      <= 3'h0;
          st_q                       <= edc_pkg::st_hold;
        end
        edc_pkg::st_hold: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `EDC_RD_STEP && !wr_q) begin
            rd_data  <= dq_i;
            rd_valid <= 1'b1;
            if (rmw_q) begin
              output_gate_n <= 1'b1;
            end
          end
          if (cnt_q == `EDC_WE_STEP && rmw_q) begin
            // late write strobe after the read
            write_strobe_n <= 1'b0;
            dq_o           <= wdata_q;
            dq_oe          <= 1'b1;
          end
          if (cnt_q == col_last) begin
            lower_lane_column_strobe_n <= 1'b1;
            upper_lane_column_strobe_n <= 1'b1;
            write_strobe_n             <= 1'b1;
            output_gate_n              <= 1'b1;
            dq_oe                      <= 1'b0;
            st_q                       <= edc_pkg::st_open;
          end
        end
        edc_pkg::st_open: begin
          if (req_valid && req_ready) begin
            st_q <= edc_pkg::st_col;
          end else if (req_valid || !no_ref || ras_long) begin
            row_strobe_n <= 1'b1;
            cnt_q        <= 3'h0;
            st_q         <= edc_pkg::st_close;
          end
        end
        edc_pkg::st_close: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == TRP_END) begin
            st_q <= edc_pkg::st_idle;
          end
        end
        edc_pkg::st_rcas: begin
          row_strobe_n <= 1'b0;
          cnt_q        <= 3'h0;
          st_q         <= edc_pkg::st_rras;
        end
        edc_pkg::st_rras: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h0) begin
            lower_lane_column_strobe_n <= 1'b1;
            upper_lane_column_strobe_n <= 1'b1;
            output_gate_n              <= 1'b1;
          end
          if (cnt_q == TRAS_END) begin
            row_strobe_n <= 1'b1;
            cnt_q        <= 3'h0;
            st_q         <= edc_pkg::st_close;
          end
        end
        default: begin
          st_q <= edc_pkg::st_idle;
        end
      endcase
    end
  end

endmodule : edc_ctrl

`default_nettype wire

// >>> edc_map.svh
`ifndef EDC_MAP_SVH
`define EDC_MAP_SVH

// Clock period
`define EDC_CLK_NS 20

// Power-up pause, then wake-up refresh count
`define EDC_TPWR_US 200
`define EDC_PWR_CYC ((`EDC_TPWR_US * 1000) / `EDC_CLK_NS)
`define EDC_WAKE_CNT 4'h8

// Rows per refresh period; spacing rounded down
`define EDC_ROWS 1024
`define EDC_TREF_MS 16
`define EDC_REF_CYC (((`EDC_TREF_MS * 1000000) / `EDC_ROWS) / `EDC_CLK_NS)

// Longest row-strobe low time in page mode, rounded down
`define EDC_TRASP_NS 100000
`define EDC_RASP_CYC (`EDC_TRASP_NS / `EDC_CLK_NS)
// Cycles kept in reserve so a column cycle in flight can finish
`define EDC_COL_GUARD 16

// Least row-strobe low and precharge times, rounded up
`define EDC_TRAS_NS 60
`define EDC_TRAS_CYC ((`EDC_TRAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_TRP_NS 40
`define EDC_TRP_CYC ((`EDC_TRP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)

// Column hold steps for the data sample and the late write strobe, and the last step for read and read-modify-write
`define EDC_RD_STEP 3'h1
`define EDC_WE_STEP 3'h2
`define EDC_RD_LAST 3'h1
`define EDC_RMW_LAST 3'h4

// Word address split
`define EDC_ROW_MSB 19
`define EDC_ROW_LSB 10
`define EDC_COL_MSB 9

`endif

// >>> edc_pkg.sv
package edc_pkg;

  typedef enum logic [3:0] {
    st_pwr   = 4'b0000,
    st_idle  = 4'b0001,
    st_ras   = 4'b0010,
    st_col   = 4'b0011,
    st_cas   = 4'b0100,
    st_hold  = 4'b0101,
    st_open  = 4'b0110,
    st_close = 4'b0111,
    st_rcas  = 4'b1000,
    st_rras  = 4'b1001
  } edc_state_t;

endpackage : edc_pkg

// >>> edc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl_props #(
  parameter int unsigned PWRUP_CYC = 20,
  parameter int unsigned RASP_CYC  = 40
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic row_strobe_n,
  input wire logic lower_lane_column_strobe_n,
  input wire logic upper_lane_column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic dq_oe
);
  wire lo = lower_lane_column_strobe_n;
  wire up = upper_lane_column_strobe_n;
  int  pw_q;
  int  rl_q;
  int  rf_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pw_q <= 0;
    else if (pw_q < PWRUP_CYC) pw_q <= pw_q + 1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rl_q <= 0;
    else rl_q <= row_strobe_n ? 0 : rl_q + 1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rf_q <= 0;
    else if (!init_done || ($fell(row_strobe_n) && !lo)) rf_q <= 0;
    else rf_q <= rf_q + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ref_start;
    !lo && !up && !output_gate_n && row_strobe_n;
  endsequence
  sequence ref_row;
    ref_start ##1 !row_strobe_n;
  endsequence
  sequence ref_release;
    !lo ##1 lo && output_gate_n && !row_strobe_n;
  endsequence
  pause_hold_a: assert property (pw_q < PWRUP_CYC |-> row_strobe_n)
    else $error("row strobe in pause");
  no_early_use_a: assert property (!init_done |-> !req_ready && write_strobe_n)
    else $error("access before wake");
  ref_gap_a: assert property (rf_q <= 800)
    else $error("refresh late");
  ras_min_a: assert property ($fell(row_strobe_n) |=> !row_strobe_n [*2])
    else $error("row low short");
  ras_max_a: assert property (rl_q < RASP_CYC)
    else $error("row low long");
  precharge_a: assert property ($rose(row_strobe_n) |-> row_strobe_n [*2])
    else $error("precharge short");
  cbr_steps_a: assert property (ref_row |-> ref_release)
    else $error("refresh order");
  early_we_a: assert property ($fell(lo) && dq_oe |-> !$past(write_strobe_n))
    else $error("write strobe late");
  read_we_a: assert property (!output_gate_n && !lo && !row_strobe_n |-> write_strobe_n)
    else $error("write in read");
  rmw_delay_a: assert property ($fell(write_strobe_n) && !lo |->
    !$past(lo, 3) && !$past(row_strobe_n, 4)) else $error("rmw write early");
  we_pulse_a: assert property ($fell(write_strobe_n) |=> !write_strobe_n)
    else $error("write pulse short");
  lanes_a: assert property (($rose(lo) || $rose(up)) && !$past(lo) && !$past(up) |->
    !$past(lo, 2) && !$past(up, 2)) else $error("lane overlap short");
endmodule : edc_ctrl_props
bind edc_ctrl edc_ctrl_props #(.PWRUP_CYC(PWRUP_CYC), .RASP_CYC(RASP_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .req_ready(req_ready), .init_done(init_done),
  .row_strobe_n(row_strobe_n), .lower_lane_column_strobe_n(lower_lane_column_strobe_n),
  .upper_lane_column_strobe_n(upper_lane_column_strobe_n), .write_strobe_n(write_strobe_n),
  .output_gate_n(output_gate_n), .dq_oe(dq_oe));
`default_nettype wire

// >>> edc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module edc_mem_model (
  input wire logic        clk,
  input wire logic [9:0]  dram_addr,
  input wire logic        row_strobe_n,
  input wire logic        lower_lane_column_strobe_n,
  input wire logic        upper_lane_column_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        output_gate_n,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe,
  output logic [15:0]     dq_i
);
  // cells hold data with no refresh from outside
  logic [15:0] mem [int];
  logic [9:0]  row_q = '0, col_q = '0;
  logic        pr = 1'b1, pl = 1'b1, pu = 1'b1;
  logic [15:0] last_q = '0, cur, tmp;
  wire lo = lower_lane_column_strobe_n;
  wire up = upper_lane_column_strobe_n;
  wire [19:0] key = {row_q, col_q};
  always @(posedge clk) begin
    if (pr && !row_strobe_n && lo && up) row_q <= dram_addr;
    if ((pl && !lo) || (pu && !up)) col_q <= dram_addr;
    if (!write_strobe_n && !row_strobe_n && dq_oe && ((!pl && !lo) || (!pu && !up))) begin
      tmp = mem.exists(key) ? mem[key] : 16'h0000;
      if (!lo) tmp[7:0] = dq_o[7:0];
      if (!up) tmp[15:8] = dq_o[15:8];
      mem[key] = tmp;
    end
    pr <= row_strobe_n;
    pl <= lo;
    pu <= up;
    last_q <= dq_i;
  end
  // data waits for the column strobe however late it falls
  always_comb begin
    cur = mem.exists(key) ? mem[key] : 16'h0000;
    dq_i = ~last_q;
    if (!output_gate_n && write_strobe_n && !lo) dq_i[7:0] = cur[7:0];
    if (!output_gate_n && write_strobe_n && !up) dq_i[15:8] = cur[15:8];
  end
endmodule : edc_mem_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_rmw = 0;
  logic [19:0] req_addr = '0;
  logic [15:0] req_wdata = '0, rd_data, dq_o, dq_i;
  logic [1:0]  req_be = '0;
  logic        req_ready, rd_valid, init_done, rs_n, ls_n, us_n, we_n, og_n, dq_oe;
  logic [9:0]  dram_addr;
  int          errors = 0, n_tests = 0, ref_m [int];
  initial forever #10 clk = ~clk;
  edc_ctrl #(.PWRUP_CYC(20), .RASP_CYC(40)) u_dut (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .dram_addr(dram_addr), .row_strobe_n(rs_n),
    .lower_lane_column_strobe_n(ls_n), .upper_lane_column_strobe_n(us_n),
    .write_strobe_n(we_n), .output_gate_n(og_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  edc_mem_model u_mem (.clk(clk), .dram_addr(dram_addr), .row_strobe_n(rs_n),
    .lower_lane_column_strobe_n(ls_n), .upper_lane_column_strobe_n(us_n),
    .write_strobe_n(we_n), .output_gate_n(og_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task do_reset;
    int i;
    @(negedge clk) arst_n = 0;
    repeat (6) @(negedge clk);
    arst_n = 1;
    for (i = 0; i < 500 && init_done !== 1'b1; i++) @(negedge clk);
    cmp({15'h0, init_done}, 16'h0001);
    cmp({15'h0, i >= 20}, 16'h0001);
  endtask : do_reset
  task access(input int op, input logic [19:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] old, m;
    int i;
    old = ref_m.exists(a) ? 16'(ref_m[a]) : 16'h0000;
    m = {{8{be[1]}}, {8{be[0]}}};
    @(negedge clk);
    req_valid = 1;
    req_write = (op == 1);
    req_rmw = (op == 2);
    req_addr = a;
    req_wdata = d;
    req_be = be;
    // Ready in an open row follows the new address; let it settle first
    #1;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clk);
    cmp({15'h0, req_ready}, 16'h0001);
    @(negedge clk) req_valid = 0;
    if (op != 1) begin
      for (i = 0; i < 50 && rd_valid !== 1'b1; i++) @(negedge clk);
      cmp({15'h0, rd_valid}, 16'h0001);
      cmp(rd_data & m, old & m);
    end
    if (op != 0) ref_m[a] = int'((old & ~m) | (d & m));
  endtask : access
  initial begin
    #(20 * 40000);
    errors++;
    finish_test();
  end
  initial begin
    logic [19:0] a;
    void'($urandom(32'h6d67));
    do_reset();
    access(1, 20'hfffff, 16'h5aa5, 2'h3);
    access(2, 20'hfffff, 16'h0ff0, 2'h2);
    for (int k = 0; k < 60; k++) begin
      a = {9'h000, 1'($urandom_range(1)), 8'h00, 2'($urandom_range(3))};
      access($urandom_range(2), a, 16'($urandom), 2'($urandom_range(3)));
    end
    repeat (2000) @(negedge clk);
    // Data must survive refresh and a mid-run reset
    for (int p = 0; p < 2; p++) begin
      foreach (ref_m[k]) access(0, 20'(k), 16'h0000, 2'h3);
      if (p == 0) do_reset();
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
